/* File: shared/sauart_defines.svh */
// Register offsets, field positions, reset values and timing counts of the spare UART
`ifndef SAUART_DEFINES_SVH
`define SAUART_DEFINES_SVH

// Register offsets (byte addresses)
`define SAUART_OFS_CTRL    8'h00
`define SAUART_OFS_STATUS  8'h04
`define SAUART_OFS_FCLR    8'h08
`define SAUART_OFS_IES     8'h0C
`define SAUART_OFS_IEC     8'h10
`define SAUART_OFS_IEM     8'h14
`define SAUART_OFS_RXH     8'h18
`define SAUART_OFS_TXH     8'h1C
`define SAUART_OFS_DIV     8'h20
`define SAUART_OFS_REV     8'h24

// Status word bit positions
`define SAUART_BIT_BUSY    0
`define SAUART_BIT_OSC     2
`define SAUART_BIT_IDLE    8
`define SAUART_BIT_RDY     9
`define SAUART_BIT_OVR     10
`define SAUART_BIT_COLL    13
`define SAUART_EVT_MASK    32'h0000_2700

// Reset values and fixed patterns
`define SAUART_MODE_RST    2'h0
`define SAUART_DIV_RST     16'h0000
`define SAUART_REV_VAL     12'hA51
`define SAUART_RATE_MUL    17'h00008
`define SAUART_SYNC_FALLS  3'h3

// Crossing latency: time in ns, cycles rounded up at the core clock
`define SAUART_CLK_MHZ     250
`define SAUART_SYNC_NS     16
`define SAUART_SYNC_CYC    ((`SAUART_SYNC_NS * `SAUART_CLK_MHZ + 999) / 1000)

`endif

/* File: shared/sauart_pkg.sv */
// Types shared by the spare UART design files
`default_nettype none
package sauart_pkg;
  typedef enum logic [1:0] {SAUART_OFF, SAUART_RX, SAUART_TX, SAUART_RXSYNC} sauart_mode_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_MEAS, RX_WAIT} sauart_rx_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sauart_tx_type;
  typedef enum logic [1:0] {PEND_NONE, PEND_CTRL, PEND_DIV, PEND_TX} sauart_pend_type;
endpackage
`default_nettype wire

/* File: hw/sauart_sync.sv */
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sauart_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Asynchronous input and its synchronised copy
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q_ff
);

  logic [WIDTH-1:0] meta_ff;

  // The first stage feeds the second stage only
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

endmodule
`default_nettype wire

/* File: hw/sauart_bitclk.sv */
// Fractional bit-rate tick generator: one tick per divisor/8 clocks
`timescale 1ns/1ps
`default_nettype none
`include "sauart_defines.svh"
module sauart_bitclk (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        restart,
  input  wire logic        half,
  input  wire logic [15:0] divisor,
  // Bit tick
  output var  logic        tick_ff
);

  logic [16:0] acc_ff;
  logic [16:0] nxt_acc;
  logic        nxt_tick;
  logic [16:0] sum;

  // Phase accumulator adds eight per clock, so the rate is 8 * f / divisor
  always_comb
  begin
    sum      = acc_ff + `SAUART_RATE_MUL;
    nxt_acc  = sum;
    nxt_tick = 1'b0;
    if (restart)
      nxt_acc = half ? {2'b00, divisor[15:1]} : 17'h00000;
    else if (sum >= {1'b0, divisor})
    begin
      nxt_tick = 1'b1;
      nxt_acc  = sum - {1'b0, divisor};
    end
  end

  // Register the phase and the tick
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      acc_ff  <= 17'h00000;
      tick_ff <= 1'b0;
    end
    else
    begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

endmodule
`default_nettype wire

/* File: hw/sauart_regs.sv */
// Spare single-pin UART: register file, crossing model, receiver and transmitter
`timescale 1ns/1ps
`default_nettype none
`include "sauart_defines.svh"
module sauart_regs #(
  parameter logic [11:0] REV_CODE = `SAUART_REV_VAL  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output var  logic [31:0] rdata_ff,
  // Serial pin
  input  wire logic        line_in,
  output var  logic        line_out_ff,
  output var  logic        line_oe_ff,
  // Oscillator state and interrupt
  input  wire logic        osc_running_in,
  output var  logic        irq_ff
);

  //----------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------
  sauart_pkg::sauart_mode_type mode_ff, nxt_mode;
  sauart_pkg::sauart_pend_type pend_ff, nxt_pend;
  sauart_pkg::sauart_rx_type   rx_st_ff, nxt_rx_st;
  sauart_pkg::sauart_tx_type   tx_st_ff, nxt_tx_st;
  logic [15:0] div_ff, nxt_div, pval_ff, nxt_pval, meas_ff, nxt_meas;
  logic [7:0]  txh_ff, nxt_txh, rxh_ff, nxt_rxh, rx_sh_ff, nxt_rx_sh, tx_sh_ff, nxt_tx_sh;
  logic [3:0]  sync_cnt_ff, nxt_sync_cnt;
  logic [2:0]  rx_n_ff, nxt_rx_n, tx_n_ff, nxt_tx_n, falls_ff, nxt_falls;
  logic [31:0] flags_ff, nxt_flags, irqp_ff, nxt_irqp, mask_ff, nxt_mask;
  logic [31:0] ev, clr, status;
  logic        sync_arm_ff, nxt_sync_arm, busy_ff, unread_ff, nxt_unread;
  logic        line_d_ff, nxt_out, nxt_oe, nxt_irq;
  logic [1:0]  pins_s;
  logic        line_s, osc_s, busy_now, wr_ok, tx_go, fall, rx_en;
  logic        store, meas_done, rx_restart, tx_restart, rx_tick, tx_tick, coll;
  logic [31:0] nxt_rdata;

  // Strobe and address match, shared by the configuration and event-flag groups
  function automatic logic acc_at(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
    acc_at = stb && (a == ofs);
  endfunction

  //----------------------------------------------------------------------
  // Pin synchronisers and bit timing
  //----------------------------------------------------------------------
  sauart_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({line_in, osc_running_in}),
    .q_ff  (pins_s)
  );

  assign line_s = pins_s[1];
  assign osc_s  = pins_s[0];

  // Receive timing starts half a bit in to sample mid-bit
  sauart_bitclk u_rx_clk (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (rx_restart),
    .half    (1'b1),
    .divisor (div_ff),
    .tick_ff (rx_tick)
  );

  sauart_bitclk u_tx_clk (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (tx_restart),
    .half    (1'b0),
    .divisor (div_ff),
    .tick_ff (tx_tick)
  );

  //----------------------------------------------------------------------
  // Configuration and crossing model
  //----------------------------------------------------------------------
  // Busy covers the crossing delay and a byte on the wire
  assign busy_now = (sync_cnt_ff != 4'h0) || (tx_st_ff != sauart_pkg::TX_IDLE);
  assign wr_ok    = wr_stb && !busy_now;

  // Control and divisor writes are parked, then committed when the crossing delay has run out; a TXH byte is stored at once and sent then if the mode is transmit
  always_comb
  begin
    nxt_mode     = mode_ff;
    nxt_div      = div_ff;
    nxt_txh      = txh_ff;
    nxt_pend     = pend_ff;
    nxt_pval     = pval_ff;
    nxt_sync_cnt = sync_cnt_ff;
    nxt_sync_arm = sync_arm_ff;
    tx_go        = 1'b0;
    if (sync_cnt_ff != 4'h0)
      nxt_sync_cnt = sync_cnt_ff - 4'h1;
    if (sync_cnt_ff == 4'h1)
    begin
      nxt_pend = sauart_pkg::PEND_NONE;
      case (pend_ff)
        sauart_pkg::PEND_CTRL:
        begin
          nxt_mode     = sauart_pkg::sauart_mode_type'(pval_ff[1:0]);
          nxt_sync_arm = (pval_ff[1:0] == 2'(sauart_pkg::SAUART_RXSYNC));
        end
        sauart_pkg::PEND_DIV:
          nxt_div = pval_ff;
        sauart_pkg::PEND_TX:
          tx_go = (mode_ff == sauart_pkg::SAUART_TX);
        default:
          nxt_pend = sauart_pkg::PEND_NONE;
      endcase
    end
    // Measured divisor replaces the programmed one until rewritten
    if (meas_done)
    begin
      nxt_div      = meas_ff + 16'h0001;
      nxt_sync_arm = 1'b0;
    end
    if (acc_at(wr_ok, addr, `SAUART_OFS_CTRL))
    begin
      nxt_pend     = sauart_pkg::PEND_CTRL;
      nxt_pval     = {14'h0000, wdata[1:0]};
      nxt_sync_cnt = 4'(`SAUART_SYNC_CYC);
    end
    else if (acc_at(wr_ok, addr, `SAUART_OFS_DIV))
    begin
      nxt_pend     = sauart_pkg::PEND_DIV;
      nxt_pval     = wdata[15:0];
      nxt_sync_cnt = 4'(`SAUART_SYNC_CYC);
    end
    else if (acc_at(wr_ok, addr, `SAUART_OFS_TXH))
    begin
      nxt_pend     = sauart_pkg::PEND_TX;
      nxt_txh      = wdata[7:0];
      nxt_sync_cnt = 4'(`SAUART_SYNC_CYC);
    end
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode_ff     <= sauart_pkg::sauart_mode_type'(`SAUART_MODE_RST);
      div_ff      <= `SAUART_DIV_RST;
      txh_ff      <= 8'h00;
      pend_ff     <= sauart_pkg::PEND_NONE;
      pval_ff     <= 16'h0000;
      sync_cnt_ff <= 4'h0;
      sync_arm_ff <= 1'b0;
      busy_ff     <= 1'b0;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      div_ff      <= nxt_div;
      txh_ff      <= nxt_txh;
      pend_ff     <= nxt_pend;
      pval_ff     <= nxt_pval;
      sync_cnt_ff <= nxt_sync_cnt;
      sync_arm_ff <= nxt_sync_arm;
      busy_ff     <= busy_now;
    end
  end

  //----------------------------------------------------------------------
  // Event flags, mask and interrupt
  //----------------------------------------------------------------------
  assign coll = (tx_st_ff != sauart_pkg::TX_IDLE) && (rx_st_ff != sauart_pkg::RX_IDLE);

  // A set in the same cycle as a clear wins in the flags; the pending bit is set only if the flag was clear
  always_comb
  begin
    ev  = 32'h0000_0000;
    clr = 32'h0000_0000;
    if (acc_at(wr_stb, addr, `SAUART_OFS_FCLR))
      clr = wdata & `SAUART_EVT_MASK;
    ev[`SAUART_BIT_COLL] = coll;
    ev[`SAUART_BIT_OVR]  = store && unread_ff;
    ev[`SAUART_BIT_RDY]  = store;
    ev[`SAUART_BIT_IDLE] = busy_ff && !busy_now;
    nxt_flags = (flags_ff & ~clr) | ev;
    nxt_irqp  = (irqp_ff & ~clr) | (ev & ~flags_ff);
    nxt_mask  = mask_ff;
    if (acc_at(wr_stb, addr, `SAUART_OFS_IES))
      nxt_mask = mask_ff | (wdata & `SAUART_EVT_MASK);
    else if (acc_at(wr_stb, addr, `SAUART_OFS_IEC))
      nxt_mask = mask_ff & ~wdata;
    nxt_irq    = |(nxt_irqp & nxt_mask);
    nxt_unread = store || (unread_ff && !acc_at(rd_stb, addr, `SAUART_OFS_RXH));
  end

  // Flag, pending and mask registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      flags_ff  <= 32'h0000_0000;
      irqp_ff   <= 32'h0000_0000;
      mask_ff   <= 32'h0000_0000;
      irq_ff    <= 1'b0;
      unread_ff <= 1'b0;
    end
    else
    begin
      flags_ff  <= nxt_flags;
      irqp_ff   <= nxt_irqp;
      mask_ff   <= nxt_mask;
      irq_ff    <= nxt_irq;
      unread_ff <= nxt_unread;
    end
  end

  //----------------------------------------------------------------------
  // Receiver and sync-byte measurement
  //----------------------------------------------------------------------
  assign fall  = line_d_ff && !line_s;
  assign rx_en = (mode_ff != sauart_pkg::SAUART_OFF);

  // Listens in every enabled mode so a collision is seen in transmit mode
  always_comb
  begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_n   = rx_n_ff;
    nxt_rxh    = rxh_ff;
    nxt_meas   = meas_ff;
    nxt_falls  = falls_ff;
    store      = 1'b0;
    meas_done  = 1'b0;
    rx_restart = 1'b0;
    case (rx_st_ff)
      sauart_pkg::RX_IDLE:
        if (rx_en && fall && !line_oe_ff)
        begin
          if (sync_arm_ff && (mode_ff == sauart_pkg::SAUART_RXSYNC))
          begin
            nxt_rx_st = sauart_pkg::RX_MEAS;
            nxt_meas  = 16'h0000;
            nxt_falls = 3'h0;
          end
          else
          begin
            nxt_rx_st  = sauart_pkg::RX_START;
            rx_restart = 1'b1;
          end
        end
      sauart_pkg::RX_START:
        if (rx_tick)
        begin
          nxt_rx_st = line_s ? sauart_pkg::RX_IDLE : sauart_pkg::RX_DATA;
          nxt_rx_n  = 3'h0;
        end
      sauart_pkg::RX_DATA:
        if (rx_tick)
        begin
          nxt_rx_sh = {line_s, rx_sh_ff[7:1]};
          nxt_rx_n  = rx_n_ff + 3'h1;
          if (rx_n_ff == 3'h7)
            nxt_rx_st = sauart_pkg::RX_STOP;
        end
      sauart_pkg::RX_STOP:
        if (rx_tick)
        begin
          nxt_rx_st = sauart_pkg::RX_IDLE;
          // Bytes are kept only in the receive modes and with a valid stop bit
          if (line_s && ((mode_ff == sauart_pkg::SAUART_RX) ||
                         (mode_ff == sauart_pkg::SAUART_RXSYNC)))
          begin
            store   = 1'b1;
            nxt_rxh = rx_sh_ff;
          end
        end
      sauart_pkg::RX_MEAS:
      begin
        // 0x55 falls at bit times 0,2,4,6,8: eight bits span one divisor
        if (meas_ff != 16'hFFFF)
          nxt_meas = meas_ff + 16'h0001;
        if (fall)
        begin
          nxt_falls = falls_ff + 3'h1;
          if (falls_ff == `SAUART_SYNC_FALLS)
          begin
            meas_done = 1'b1;
            nxt_rx_st = sauart_pkg::RX_WAIT;
          end
        end
      end
      sauart_pkg::RX_WAIT:
        if (line_s)
          nxt_rx_st = sauart_pkg::RX_IDLE;
      default:
        nxt_rx_st = sauart_pkg::RX_IDLE;
    endcase
    if (!rx_en)
      nxt_rx_st = sauart_pkg::RX_IDLE;
  end

  // Receiver registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_st_ff  <= sauart_pkg::RX_IDLE;
      rx_sh_ff  <= 8'h00;
      rx_n_ff   <= 3'h0;
      rxh_ff    <= 8'h00;
      meas_ff   <= 16'h0000;
      falls_ff  <= 3'h0;
      line_d_ff <= 1'b1;
    end
    else
    begin
      rx_st_ff  <= nxt_rx_st;
      rx_sh_ff  <= nxt_rx_sh;
      rx_n_ff   <= nxt_rx_n;
      rxh_ff    <= nxt_rxh;
      meas_ff   <= nxt_meas;
      falls_ff  <= nxt_falls;
      line_d_ff <= line_s;
    end
  end

  //----------------------------------------------------------------------
  // Transmitter
  //----------------------------------------------------------------------
  // Start bit, eight data bits LSB first, one stop bit; pin released after
  always_comb
  begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_tx_n   = tx_n_ff;
    nxt_out    = line_out_ff;
    nxt_oe     = line_oe_ff;
    tx_restart = 1'b0;
    case (tx_st_ff)
      sauart_pkg::TX_IDLE:
        if (tx_go)
        begin
          nxt_tx_st  = sauart_pkg::TX_START;
          nxt_tx_sh  = txh_ff;
          tx_restart = 1'b1;
          nxt_out    = 1'b0;
          nxt_oe     = 1'b1;
        end
      sauart_pkg::TX_START:
        if (tx_tick)
        begin
          nxt_tx_st = sauart_pkg::TX_DATA;
          nxt_tx_n  = 3'h0;
          nxt_out   = tx_sh_ff[0];
        end
      sauart_pkg::TX_DATA:
        if (tx_tick)
        begin
          nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
          nxt_tx_n  = tx_n_ff + 3'h1;
          nxt_out   = tx_sh_ff[1];
          if (tx_n_ff == 3'h7)
          begin
            nxt_tx_st = sauart_pkg::TX_STOP;
            nxt_out   = 1'b1;
          end
        end
      sauart_pkg::TX_STOP:
        if (tx_tick)
        begin
          nxt_tx_st = sauart_pkg::TX_IDLE;
          nxt_oe    = 1'b0;
        end
      default:
        nxt_tx_st = sauart_pkg::TX_IDLE;
    endcase
    // Turning the block off abandons a byte and frees the pin at once
    if (mode_ff == sauart_pkg::SAUART_OFF)
    begin
      nxt_tx_st = sauart_pkg::TX_IDLE;
      nxt_out   = 1'b1;
      nxt_oe    = 1'b0;
    end
  end

  // Transmitter registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_st_ff    <= sauart_pkg::TX_IDLE;
      tx_sh_ff    <= 8'h00;
      tx_n_ff     <= 3'h0;
      line_out_ff <= 1'b1;
      line_oe_ff  <= 1'b0;
    end
    else
    begin
      tx_st_ff    <= nxt_tx_st;
      tx_sh_ff    <= nxt_tx_sh;
      tx_n_ff     <= nxt_tx_n;
      line_out_ff <= nxt_out;
      line_oe_ff  <= nxt_oe;
    end
  end

  //----------------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------------
  // Status shows live busy and oscillator state beside the sticky flags
  always_comb
  begin
    status                  = flags_ff;
    status[`SAUART_BIT_BUSY] = busy_now;
    status[`SAUART_BIT_OSC]  = osc_s;
    nxt_rdata               = 32'h0000_0000;
    if (!rd_stb)
      nxt_rdata = 32'h0000_0000;
    else if (addr == `SAUART_OFS_CTRL)
      nxt_rdata = {30'h0000_0000, mode_ff};
    else if (addr == `SAUART_OFS_STATUS)
      nxt_rdata = status;
    else if (addr == `SAUART_OFS_IEM)
      nxt_rdata = mask_ff;
    else if (addr == `SAUART_OFS_RXH)
      nxt_rdata = {24'h00_0000, rxh_ff};
    else if (addr == `SAUART_OFS_TXH)
      nxt_rdata = {24'h00_0000, txh_ff};
    else if (addr == `SAUART_OFS_DIV)
      nxt_rdata = {16'h0000, div_ff};
    else if (addr == `SAUART_OFS_REV)
      nxt_rdata = {20'h0_0000, REV_CODE};
  end

  // Read data stand for the one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= nxt_rdata;
  end

endmodule
`default_nettype wire

/* File: tb/sauart_regs_sva.sv */
// Checker for the spare UART register block
`timescale 1ns/1ps
`default_nettype none
module sauart_regs_sva #(
  parameter logic [11:0] REV_CODE = 12'h000
) (
  // Clock, reset and register port
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [31:0] rdata_ff,
  // Pin, oscillator and interrupt
  input  wire logic        line_in,
  input  wire logic        line_out_ff,
  input  wire logic        line_oe_ff,
  input  wire logic        osc_running_in,
  input  wire logic        irq_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_rev;
    rd_stb && addr == 8'h24 |=> rdata_ff == {20'h0, REV_CODE};
  endproperty
  a_rev: assert property (p_rev) else $error("bad version read");
  property p_rxh;
    rd_stb && addr == 8'h18 |=> rdata_ff[31:8] == 24'h0;
  endproperty
  a_rxh: assert property (p_rxh) else $error("bad rx holding read");
  property p_msk;
    rd_stb && addr == 8'h14 |=> (rdata_ff & ~32'h0000_2700) == 32'h0;
  endproperty
  a_msk: assert property (p_msk) else $error("mask outside event bits");
  // Four cycles covers the two-flop crossing of the oscillator level
  property p_osc;
    (rst_b && osc_running_in) [*4] ##0 (rd_stb && addr == 8'h04) |=> rdata_ff[2];
  endproperty
  a_osc: assert property (p_osc) else $error("clock running bit low");
  property p_busy;
    wr_stb && addr == 8'h00 ##1 rd_stb && addr == 8'h04 |=> rdata_ff[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_ies;
    wr_stb && addr == 8'h0C ##1 rd_stb && addr == 8'h14
      |=> (rdata_ff & $past(wdata, 2) & 32'h2700) == ($past(wdata, 2) & 32'h2700);
  endproperty
  a_ies: assert property (p_ies) else $error("mask bit not set");
  property p_iec;
    wr_stb && addr == 8'h10 ##1 rd_stb && addr == 8'h14 |=> (rdata_ff & $past(wdata, 2)) == 0;
  endproperty
  a_iec: assert property (p_iec) else $error("mask bit not cleared");
  property p_fclr;
    wr_stb && addr == 8'h08 && wdata[8] ##1 rd_stb && addr == 8'h04 |=> !rdata_ff[8];
  endproperty
  a_fclr: assert property (p_fclr) else $error("idle flag not cleared");
  property p_irq;
    wr_stb && addr == 8'h10 && wdata == 32'h2700 |=> !irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
  property p_start;
    $rose(line_oe_ff) |-> !line_out_ff;
  endproperty
  a_start: assert property (p_start) else $error("frame without start bit");
endmodule

bind sauart_regs sauart_regs_sva #(.REV_CODE(REV_CODE)) sauart_regs_sva_inst (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata_ff(rdata_ff), .line_in(line_in), .line_out_ff(line_out_ff),
  .line_oe_ff(line_oe_ff), .osc_running_in(osc_running_in), .irq_ff(irq_ff));
`default_nettype wire

/* File: tb/sauart_peer.sv */
// Serial peer: sends 8N1 frames and decodes frames sent by the block
`timescale 1ns/1ps
`default_nettype none
module sauart_peer (
  // Clock, shared line and bit time in clocks
  input  wire logic        clk,
  input  wire logic        line,
  input  wire logic [15:0] bit_clks,
  // Peer drive and decoded byte
  output var  logic        tx_ff,
  output var  logic        got_ff,
  output var  logic [7:0]  byte_ff
);
  logic sending = 1'b0;
  initial
  begin
    tx_ff = 1'b1;
    got_ff = 1'b0;
    byte_ff = 8'h00;
  end
  // Start, eight data bits LSB first, stop; idle level is high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      tx_ff <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    sending = 1'b0;
  endtask
  // Own frames are skipped so the peer never echoes itself
  always
  begin
    @(negedge line);
    if (!sending)
    begin
      repeat (bit_clks + bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        byte_ff <= {line, byte_ff[7:1]};
        repeat (bit_clks) @(posedge clk);
      end
      got_ff <= 1'b1;
      @(posedge clk);
      got_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_sauart_regs.sv */
// Self-checking bench for the spare UART register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sauart_regs;
  localparam logic [11:0] REV = 12'h3C7;  // Arbitrary value
  localparam logic [7:0] OFS [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                                      8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        rd_q = 1'b0;
  logic        osc = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [15:0] bit_clks = 16'd8;
  logic [7:0]  b;
  logic [7:0]  lb;
  logic [63:0] ent;
  logic [63:0] rq [$];
  logic [7:0]  lq [$];
  int          err_count = 0;
  int          cmp_count = 0;
  wire logic [31:0] rdata;
  wire logic        lout;
  wire logic        loe;
  wire logic        irq;
  wire logic        ptx;
  wire logic        pgot;
  wire logic [7:0]  pbyte;
  // Shared pin: the block wins while it drives, else the peer
  wire logic        line = loe ? lout : ptx;

  always #2 clk = ~clk;

  sauart_regs #(.REV_CODE(REV)) sauart_regs_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_ff(rdata), .line_in(line), .line_out_ff(lout),
    .line_oe_ff(loe), .osc_running_in(osc), .irq_ff(irq));
  sauart_peer sauart_peer_inst (.clk(clk), .line(line), .bit_clks(bit_clks),
    .tx_ff(ptx), .got_ff(pgot), .byte_ff(pbyte));

  // Bus tasks set each strobe once per edge so back-to-back cycles are safe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    rq.push_back({m, e});
    @(posedge clk);
  endtask
  task automatic nop(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // Poll busy under a bound; a frame lasts about eighty clocks
  task automatic idle();
    logic bz;
    int n;
    bz = 1'b1;
    n = 0;
    while (bz === 1'b1 && n < 200)
    begin
      rd(8'h04, 32'h0, 32'h0);
      rd_stb <= 1'b0;
      #1 bz = rdata[0];
      @(posedge clk);
      n++;
    end
    `CHK(bz, 1'b0)
  endtask
  task automatic irqk(input logic e);
    nop(3);
    #1 `CHK(irq, e)
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watcher: read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_q && rq.size() > 0)
    begin
      ent = rq.pop_front();
      if (ent[63:32] != 32'h0) `CHK(rdata & ent[63:32], ent[31:0])
    end
    if (pgot && lq.size() > 0)
    begin
      lb = lq.pop_front();
      `CHK(pbyte, lb)
    end
    rd_q <= rd_stb;
  end

  initial
  begin
    #(4 * 20000);
    err_count++;
    $display("watchdog expired");
    summarize();
  end

  initial
  begin
    void'($urandom(32'h7828));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (OFS[i]) rd(OFS[i], 32'hFFFF_FFFF, (OFS[i] == 8'h24) ? {20'h0, REV} : 32'h0);
    $display("reset values done");
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0000_2700);
    wr(8'h10, 32'h0);
    wr(8'h10, 32'h0000_0500);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0000_2200);
    wr(8'h10, 32'h0000_2700);
    osc <= 1'b1;
    nop(5);
    rd(8'h04, 32'h4, 32'h4);
    wr(8'h20, 32'd64);
    wr(8'h20, 32'h0000_1234);
    rd(8'h04, 32'h1, 32'h1);
    idle();
    rd(8'h20, 32'hFFFF_FFFF, 32'd64);
    rd(8'h04, 32'h100, 32'h100);
    wr(8'h08, 32'h100);
    rd(8'h04, 32'h100, 32'h0);
    $display("register test done");
    wr(8'h00, 32'h2);
    rd(8'h04, 32'h1, 32'h1);
    idle();
    wr(8'h08, 32'h2700);
    wr(8'h0C, 32'h100);
    b = 8'($urandom);
    lq.push_back(b);
    wr(8'h1C, {24'h0, b});
    idle();
    rd(8'h1C, 32'hFF, {24'h0, b});
    irqk(1'b1);
    wr(8'h10, 32'h100);
    irqk(1'b0);
    wr(8'h0C, 32'h100);
    irqk(1'b1);
    wr(8'h08, 32'h100);
    irqk(1'b0);
    wr(8'h10, 32'h2700);
    nop(1);
    fork
      sauart_peer_inst.send(8'hA5);
      begin
        nop(20);
        wr(8'h1C, 32'h5A);
        nop(1);
      end
    join
    idle();
    rd(8'h04, 32'h2000, 32'h2000);
    $display("transmit test done");
    wr(8'h00, 32'h1);
    idle();
    wr(8'h08, 32'h2700);
    for (int i = 0; i < 2; i++)
    begin
      b = 8'($urandom);
      nop(1);
      sauart_peer_inst.send(b);
      nop(8);
      rd(8'h04, 32'h200, 32'h200);
      rd(8'h04, 32'h400, (i == 1) ? 32'h400 : 32'h0);
    end
    rd(8'h18, 32'hFFFF_FFFF, {24'h0, b});
    wr(8'h00, 32'h0);
    idle();
    wr(8'h08, 32'h2700);
    nop(1);
    sauart_peer_inst.send(8'($urandom));
    nop(8);
    rd(8'h04, 32'h200, 32'h0);
    $display("receive test done");
    wr(8'h00, 32'h3);
    idle();
    wr(8'h08, 32'h2700);
    bit_clks <= 16'd10;
    nop(1);
    sauart_peer_inst.send(8'h55);
    nop(8);
    rd(8'h20, 32'hFFFF, 32'd80);
    rd(8'h04, 32'h200, 32'h0);
    b = 8'($urandom);
    nop(1);
    sauart_peer_inst.send(b);
    nop(8);
    rd(8'h18, 32'hFF, {24'h0, b});
    nop(4);
    $display("resync test done");
    `CHK(lq.size() == 0, 1'b1)
    summarize();
  end
endmodule
`default_nettype wire
